// ==== hw/wlqss_pkg.sv ====
// Purpose: Shared constants and types for the word list queue/stack/sort
// Assumes: 16-bit word-addressed data memory with one-cycle read latency
// Notes: Summary of operation follows
// Summary of operation
// R1: A list is consecutive 16-bit words; enter at first, leave first or last.
// R2: Push/pop base word holds the pointer; first entry follows it.
// R3: Entry address is pointer address plus pointer value; value 1 is first.
// R4: Push with pointer below count shifts entries down, writes source first.
// R5: Push increments the pointer on every insert.
// R6: Push with pointer at count leaves list and pointer, drops source.
// R7: Push power output is high when pointer equals entry count.
// R8: Pop-back with nonzero pointer copies selected entry, decrements pointer.
// R9: Pop-back moves no entries; only target and pointer change.
// R10: Pop-front copies first entry, shifts rest up, decrements pointer.
// R11: Both pops drive power output high when pointer equals zero.
// R12: Caller gives push/pop entry count 1 to 255.
// R13: Caller places list base inside register space or byte-aligned I/O.
// R14: Copies keep the source and overwrite the target.
// R15: Sort rewrites the value list in ascending order in place.
// R16: Sort fills a second list with each value's original 1-based position.
// R17: Sort uses no pointer; first address is the first value.
// R18: Caller gives sort entry count 1 to 63.
// R19: Caller places both sort lists in register memory.
// R20: Sort power output follows its power input.
// R21: Power input tied high runs the operation every scan.
// R22: Sort compares signed values and keeps equal values in order.
// R23: Each operation completes before the next; power output holds until next.
package wlqss_pkg;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 16;
  localparam int CNT_W      = 8;
  localparam int IDX_W      = 9;
  localparam int POS_W      = 6;
  localparam int SORT_DEPTH = 63;
  localparam int FIFO_DEPTH = 4;
  localparam logic [IDX_W-1:0] FIRST_ENTRY = 9'h001;
  localparam logic [IDX_W-1:0] SECOND_ENTRY = 9'h002;

  typedef enum logic [1:0] {
    PUSH_FRONT_OP = 2'h0,
    POP_BACK_OP   = 2'h1,
    POP_FRONT_OP  = 2'h2,
    SORT_OP       = 2'h3
  } wlqss_op_t;

  typedef struct packed {
    wlqss_op_t         op;
    logic              power_in;
    logic [ADDR_W-1:0] source_ref;
    logic [ADDR_W-1:0] list_ref;
    logic [ADDR_W-1:0] target_ref;
    logic [CNT_W-1:0]  entry_count;
  } wlqss_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] val;
    logic [POS_W-1:0]  pos;
  } wlqss_slot_t;

  typedef enum logic [13:0] {
    ST_IDLE = 14'h0001,
    ST_PTRW = 14'h0002,
    ST_SHR  = 14'h0004,
    ST_SHW  = 14'h0008,
    ST_SRC  = 14'h0010,
    ST_CPY  = 14'h0020,
    ST_PWR  = 14'h0040,
    ST_SLD  = 14'h0080,
    ST_SKEY = 14'h0100,
    ST_SCMP = 14'h0200,
    ST_SINS = 14'h0400,
    ST_SRD  = 14'h0800,
    ST_SWA  = 14'h1000,
    ST_SWB  = 14'h2000
  } wlqss_state_t;
endpackage

// ==== hw/wlqss_fifo.sv ====
// Purpose: Command queue between scan sequencer and list engine
// Assumes: Single clock, synchronous reset
// Notes: Head word is read straight from the storage flops
`timescale 1ns/1ps
`default_nettype none
module wlqss_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } wlqss_fifo_st_t;
  wlqss_fifo_st_t q, d;
  logic push, pop;

  assign in_ready  = (q.cnt != DEPTH[AW:0]);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];

  always_comb begin
    d = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ==== hw/wlqss_sort_mem.sv ====
// Purpose: Sort scratch store of value and position pairs
// Assumes: One write and one read port, registered read data
// Notes: A read of the address written in the same cycle returns old data
`timescale 1ns/1ps
`default_nettype none
module wlqss_sort_mem #(
  parameter int W     = 22,
  parameter int DEPTH = 63
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [W-1:0]             wdata,
  // Read port
  input  wire logic                     re,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0]                  rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rd;
  } wlqss_smem_st_t;
  wlqss_smem_st_t q, d;

  assign rdata = q.rd;

  always_comb begin
    d = q;
    if (re) begin
      d.rd = q.mem[raddr];
    end
    if (we) begin
      d.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ==== hw/wlqss_engine.sv ====
// Purpose: Push, pop-back, pop-front and sort on lists in data memory
// Assumes: Memory returns read data the cycle after mem_re
// Notes: One command runs to completion before the next leaves the queue
`timescale 1ns/1ps
`default_nettype none
module wlqss_engine #(
  parameter int QDEPTH = 4
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Scan sequencer commands
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire wlqss_pkg::wlqss_cmd_t      cmd,
  // Scan results
  output logic                            done,
  output logic                            power_out,
  // Data memory
  output logic                            mem_re,
  output logic                            mem_we,
  output logic [wlqss_pkg::ADDR_W-1:0]    mem_addr,
  output logic [wlqss_pkg::DATA_W-1:0]    mem_wdata,
  input  wire logic [wlqss_pkg::DATA_W-1:0] mem_rdata
);
  import wlqss_pkg::*;

  typedef struct packed {
    wlqss_state_t      state;
    wlqss_op_t         op;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] lst;
    logic [ADDR_W-1:0] tgt;
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] ptr;
    logic [IDX_W-1:0]  idx;
    logic [POS_W:0]    j;
    logic [DATA_W-1:0] key;
    logic              done;
    logic              pwr;
  } wlqss_st_t;

  localparam int SLOT_W = $bits(wlqss_slot_t);
  localparam int SA_W   = $clog2(SORT_DEPTH);

  wlqss_st_t   q, d;
  wlqss_cmd_t  fc;
  logic        fvalid, deq;
  logic        lm_re, lm_we;
  logic [SA_W-1:0] lm_raddr, lm_waddr;
  wlqss_slot_t lm_wdata, lm_rdata;
  logic [DATA_W-1:0] cnt_w;

  function automatic logic [ADDR_W-1:0] at(input logic [ADDR_W-1:0] base,
                                           input logic [IDX_W-1:0] off);
    at = base + ADDR_W'(off);
  endfunction

  // Queue lets the sequencer run ahead while a long shift or sort runs
  wlqss_fifo #(
    .W     ($bits(wlqss_cmd_t)),
    .DEPTH (QDEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (fvalid),
    .out_ready (deq),
    .out_data  (fc)
  );

  wlqss_sort_mem #(
    .W     (SLOT_W),
    .DEPTH (SORT_DEPTH)
  ) u_smem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .we      (lm_we),
    .waddr   (lm_waddr),
    .wdata   (lm_wdata),
    .re      (lm_re),
    .raddr   (lm_raddr),
    .rdata   (lm_rdata)
  );

  assign done      = q.done;
  assign power_out = q.pwr;
  assign cnt_w     = DATA_W'(q.cnt);

  always_comb begin
    d = q;
    d.done    = 1'b0;
    deq       = 1'b0;
    mem_re    = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = '0;
    mem_wdata = '0;
    lm_re     = 1'b0;
    lm_we     = 1'b0;
    lm_raddr  = '0;
    lm_waddr  = '0;
    lm_wdata  = '0;
    unique case (q.state)
      ST_IDLE: begin
        if (fvalid) begin
          deq   = 1'b1;
          d.op  = fc.op;
          d.src = fc.source_ref;
          d.lst = fc.list_ref;
          d.tgt = fc.target_ref;
          d.cnt = fc.entry_count;
          d.idx = '0;
          if (!fc.power_in) begin
            d.done = 1'b1;
            d.pwr  = 1'b0;
          end else if (fc.op == SORT_OP) begin
            d.state = ST_SLD; // R17
          end else begin
            mem_re   = 1'b1; // R21
            mem_addr = fc.list_ref; // R2
            d.state  = ST_PTRW;
          end
        end
      end
      ST_PTRW: begin
        d.ptr = mem_rdata;
        unique case (q.op)
          PUSH_FRONT_OP: begin
            if (mem_rdata < cnt_w) begin
              d.idx   = mem_rdata[IDX_W-1:0]; // R4
              d.state = (mem_rdata == '0) ? ST_SRC : ST_SHR;
            end else begin
              d.done  = 1'b1; // R6
              d.pwr   = (mem_rdata == cnt_w); // R7
              d.state = ST_IDLE;
            end
          end
          POP_BACK_OP: begin
            if (mem_rdata != '0) begin
              mem_re   = 1'b1;
              mem_addr = at(q.lst, mem_rdata[IDX_W-1:0]); // R3 R8
              d.state  = ST_CPY;
            end else begin
              d.done  = 1'b1;
              d.pwr   = 1'b1; // R11
              d.state = ST_IDLE;
            end
          end
          default: begin
            if (mem_rdata != '0) begin
              mem_re   = 1'b1;
              mem_addr = at(q.lst, FIRST_ENTRY); // R10
              d.idx    = SECOND_ENTRY;
              d.state  = ST_CPY;
            end else begin
              d.done  = 1'b1;
              d.pwr   = 1'b1; // R11
              d.state = ST_IDLE;
            end
          end
        endcase
      end
      ST_SHR: begin
        mem_re   = 1'b1;
        mem_addr = at(q.lst, q.idx);
        d.state  = ST_SHW;
      end
      ST_SHW: begin
        mem_we    = 1'b1;
        mem_wdata = mem_rdata;
        if (q.op == PUSH_FRONT_OP) begin
          // Walk from the last entry upward so nothing is overwritten early
          mem_addr = at(q.lst, q.idx + 1'b1); // R4
          d.idx    = q.idx - 1'b1;
          d.state  = (q.idx == FIRST_ENTRY) ? ST_SRC : ST_SHR;
        end else begin
          mem_addr = at(q.lst, q.idx - 1'b1); // R10
          d.idx    = q.idx + 1'b1;
          d.state  = (DATA_W'(q.idx) == q.ptr) ? ST_PWR : ST_SHR;
        end
      end
      ST_SRC: begin
        mem_re   = 1'b1;
        mem_addr = q.src;
        d.state  = ST_CPY;
      end
      ST_CPY: begin
        mem_we    = 1'b1;
        mem_wdata = mem_rdata; // R14
        if (q.op == PUSH_FRONT_OP) begin
          mem_addr = at(q.lst, FIRST_ENTRY); // R1 R4
          d.state  = ST_PWR;
        end else begin
          mem_addr = q.tgt; // R9 R14
          d.state  = (q.op == POP_FRONT_OP && DATA_W'(q.idx) <= q.ptr) ?
                     ST_SHR : ST_PWR;
        end
      end
      ST_PWR: begin
        mem_we   = 1'b1;
        mem_addr = q.lst;
        d.done   = 1'b1;
        d.state  = ST_IDLE;
        if (q.op == PUSH_FRONT_OP) begin
          mem_wdata = q.ptr + 1'b1; // R5
          d.pwr     = (q.ptr + 1'b1 == cnt_w); // R7
        end else begin
          mem_wdata = q.ptr - 1'b1; // R8 R10
          d.pwr     = (q.ptr == DATA_W'(1)); // R11
        end
      end
      ST_SLD: begin
        mem_re   = 1'b1;
        mem_addr = at(q.lst, q.idx);
        d.state  = ST_SKEY;
      end
      ST_SKEY: begin
        d.key = mem_rdata;
        d.j   = q.idx[POS_W:0];
        if (q.idx == '0) begin
          d.state = ST_SINS;
        end else begin
          lm_re    = 1'b1;
          lm_raddr = SA_W'(q.idx - 1'b1);
          d.state  = ST_SCMP;
        end
      end
      ST_SCMP: begin
        // Strictly greater only, so equal values keep their order
        if ($signed(lm_rdata.val) > $signed(q.key)) begin // R22
          lm_we    = 1'b1;
          lm_waddr = SA_W'(q.j);
          lm_wdata = lm_rdata;
          d.j      = q.j - 1'b1;
          if (q.j == (POS_W+1)'(1)) begin
            d.state = ST_SINS;
          end else begin
            lm_re    = 1'b1;
            lm_raddr = SA_W'(q.j - 2'h2);
          end
        end else begin
          d.state = ST_SINS;
        end
      end
      ST_SINS: begin
        lm_we        = 1'b1;
        lm_waddr     = SA_W'(q.j);
        lm_wdata.val = q.key;
        lm_wdata.pos = POS_W'(q.idx + 1'b1); // R16
        if (q.idx + 1'b1 == IDX_W'(q.cnt)) begin
          d.idx   = '0;
          d.state = ST_SRD;
        end else begin
          d.idx   = q.idx + 1'b1;
          d.state = ST_SLD;
        end
      end
      ST_SRD: begin
        lm_re    = 1'b1;
        lm_raddr = SA_W'(q.idx);
        d.state  = ST_SWA;
      end
      ST_SWA: begin
        mem_we    = 1'b1;
        mem_addr  = at(q.lst, q.idx); // R15
        mem_wdata = lm_rdata.val;
        d.state   = ST_SWB;
      end
      ST_SWB: begin
        mem_we    = 1'b1;
        mem_addr  = at(q.tgt, q.idx); // R16
        mem_wdata = DATA_W'(lm_rdata.pos);
        if (q.idx + 1'b1 == IDX_W'(q.cnt)) begin
          d.done  = 1'b1;
          d.pwr   = 1'b1; // R20
          d.state = ST_IDLE;
        end else begin
          d.idx   = q.idx + 1'b1;
          d.state = ST_SRD;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q       <= '0;
      q.state <= ST_IDLE;
    end else begin
      q <= d; // R23
    end
  end

  // Assertion helpers
  logic [DATA_W-1:0] last_val_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_val_q <= '0;
    end else if (q.state == ST_SWA) begin
      last_val_q <= mem_wdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_push_full;
    q.state == ST_PTRW && q.op == PUSH_FRONT_OP && mem_rdata >= cnt_w;
  endsequence
  sequence s_idle_done;
    q.done && q.state == ST_IDLE && !mem_we;
  endsequence

  // An unpowered command finishes at once, so it may follow a done directly
  AST_DONE_PULSE: assert property (done |=> !done // R23
      || $past(q.state == ST_IDLE && fvalid && !fc.power_in))
    else $error("done lasted more than one cycle");
  AST_FULL_NOWRITE: assert property (s_push_full |=> s_idle_done) // R6
    else $error("push on full list wrote memory");
  AST_PUSH_PWR: assert property (q.state == ST_PWR // R7
      && q.op == PUSH_FRONT_OP |=> done
      && power_out == ($past(q.ptr) + 1'b1 == $past(cnt_w)))
    else $error("push power output wrong");
  AST_PTR_INC: assert property (q.state == ST_PWR // R5
      && q.op == PUSH_FRONT_OP |-> mem_we && mem_addr == q.lst
      && mem_wdata == q.ptr + 1'b1)
    else $error("push pointer not incremented");
  AST_POP_EMPTY: assert property (q.state == ST_PTRW // R11
      && q.op != PUSH_FRONT_OP && q.op != SORT_OP && mem_rdata == '0
      |=> done && power_out)
    else $error("pop of empty list lacks power output");
  AST_POPB_ADDR: assert property (q.state == ST_PTRW // R8
      && q.op == POP_BACK_OP && mem_rdata != '0
      |-> mem_re && mem_addr == q.lst + mem_rdata ##1 mem_we
      && mem_addr == q.tgt)
    else $error("pop-back read wrong entry");
  AST_SORT_ASC: assert property (q.state == ST_SWA && q.idx != '0 // R15
      |-> $signed(mem_wdata) >= $signed(last_val_q))
    else $error("sorted list not ascending");
  AST_SORT_PWR: assert property (done && q.op == SORT_OP // R20
      |-> power_out == $past(q.state == ST_SWB))
    else $error("sort power output wrong");
  AST_POS_RANGE: assert property (q.state == ST_SWB // R16
      |-> mem_wdata != '0 && mem_wdata <= cnt_w)
    else $error("sort position out of range");
endmodule
`default_nettype wire

// ==== testbench/wlqss_mem_model.sv ====
// Purpose: Word-addressed data memory on the far side of the list engine
// Assumes: One-cycle read latency, read and write strobes never together
// Notes: Idle read data flips each cycle so a late sample is caught
`timescale 1ns/1ps
`default_nettype none
module wlqss_mem_model (
  // Clock
  input  wire logic                         clk,
  // Access from the engine
  input  wire logic                         mem_re,
  input  wire logic                         mem_we,
  input  wire logic [wlqss_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [wlqss_pkg::DATA_W-1:0] mem_wdata,
  output var  logic [wlqss_pkg::DATA_W-1:0] mem_rdata
);
  import wlqss_pkg::*;

  logic [DATA_W-1:0] mem [0:4095];

  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'h0000;
    end
  end

  always @(posedge clk) begin
    if (mem_we) begin
      mem[mem_addr[11:0]] <= mem_wdata;
    end
    if (mem_re) begin
      mem_rdata <= mem[mem_addr[11:0]];
    end else begin
      // Stale data would hide a read sampled a cycle late
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/wlqss_bench.sv ====
// Purpose: Self-checking bench for the list engine
// Assumes: Counts 1 to 255 for push/pop and 1 to 63 for sort
// Notes: Memory contents are checked through the model's array
`timescale 1ns/1ps
`default_nettype none
module wlqss_bench;
  import wlqss_pkg::*;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready;
  wlqss_cmd_t  cmd = '0;
  logic        done;
  logic        power_out;
  logic        mem_re;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  int          bad_count = 0;
  int          n_tests = 0;
  int          done_cnt = 0;
  logic        saw_full = 1'b0;

  wlqss_engine #(.QDEPTH(4)) wlqss_engine_i (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .done(done), .power_out(power_out),
    .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  wlqss_mem_model wlqss_mem_model_i (
    .clk(clk), .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (done === 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] rd(input int a);
    return wlqss_mem_model_i.mem[a];
  endfunction

  task automatic poke(input int a, input logic [15:0] v);
    wlqss_mem_model_i.mem[a] = v;
  endtask

  // Valid stays up on return so back-to-back sends never drop it
  task automatic send(input wlqss_op_t op, input logic pin,
                      input logic [15:0] src, input logic [15:0] lst,
                      input logic [15:0] tgt, input logic [7:0] n);
    int k;
    k = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op, pin, src, lst, tgt, n};
    while (cmd_ready !== 1'b1 && k < 2000) begin
      saw_full = 1'b1;
      @(negedge clk);
      k++;
    end
    check("cmd ready", 16'h0001, {15'h0, cmd_ready});
    @(posedge clk);
  endtask

  task automatic wait_done(input int target);
    int k;
    k = 0;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done_cnt < target && k < 5000) begin
      @(negedge clk);
      k++;
    end
    check("done count", target[15:0], done_cnt[15:0]);
  endtask

  task automatic run(input wlqss_op_t op, input logic pin,
                     input logic [15:0] src, input logic [15:0] lst,
                     input logic [15:0] tgt, input logic [7:0] n);
    int t;
    t = done_cnt + 1;
    send(op, pin, src, lst, tgt, n);
    wait_done(t);
  endtask

  task automatic t_push;
    poke('h10, 16'h0000);
    poke('h200, 16'hAAAA);
    poke('h201, 16'h5555);
    run(PUSH_FRONT_OP, 1'b1, 16'h0200, 16'h0010, 16'h0000, 8'h02);
    check("push ptr", 16'h0001, rd('h10));
    check("push first", 16'hAAAA, rd('h11));
    check("push src kept", 16'hAAAA, rd('h200));
    check("push pwr", 16'h0000, {15'h0, power_out});
    run(PUSH_FRONT_OP, 1'b1, 16'h0201, 16'h0010, 16'h0000, 8'h02);
    check("push first", 16'h5555, rd('h11));
    check("push shifted", 16'hAAAA, rd('h12));
    check("push pwr full", 16'h0001, {15'h0, power_out});
    run(PUSH_FRONT_OP, 1'b1, 16'h0200, 16'h0010, 16'h0000, 8'h02);
    check("full ptr", 16'h0002, rd('h10));
    check("full first", 16'h5555, rd('h11));
    check("full second", 16'hAAAA, rd('h12));
    check("full past end", 16'h0000, rd('h13));
    check("full pwr", 16'h0001, {15'h0, power_out});
  endtask

  // Reset between tests drops the held power output and leaves the queue ready
  task automatic t_reset;
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    check("rst pwr", 16'h0000, {15'h0, power_out});
    check("rst ready", 16'h0001, {15'h0, cmd_ready});
    check("rst done", 16'h0000, {15'h0, done});
  endtask

  task automatic t_pop_back;
    poke('h300, 16'hFFFF);
    run(POP_BACK_OP, 1'b1, 16'h0000, 16'h0010, 16'h0300, 8'h02);
    check("back tgt", 16'hAAAA, rd('h300));
    check("back ptr", 16'h0001, rd('h10));
    check("back kept 1", 16'h5555, rd('h11));
    check("back kept 2", 16'hAAAA, rd('h12));
    check("back pwr", 16'h0000, {15'h0, power_out});
    run(POP_BACK_OP, 1'b1, 16'h0000, 16'h0010, 16'h0300, 8'h02);
    check("back tgt", 16'h5555, rd('h300));
    check("back pwr empty", 16'h0001, {15'h0, power_out});
    poke('h300, 16'h0F0F);
    run(POP_BACK_OP, 1'b1, 16'h0000, 16'h0010, 16'h0300, 8'h02);
    check("empty tgt", 16'h0F0F, rd('h300));
    check("empty ptr", 16'h0000, rd('h10));
    check("empty pwr", 16'h0001, {15'h0, power_out});
  endtask

  task automatic t_pop_front;
    poke('h20, 16'h0003);
    for (int i = 1; i <= 3; i++) begin
      poke('h20 + i, 16'h1111 * i);
    end
    for (int i = 1; i <= 3; i++) begin
      run(POP_FRONT_OP, 1'b1, 16'h0000, 16'h0020, 16'h0301, 8'h05);
      check("front tgt", 16'h1111 * i, rd('h301));
      check("front ptr", 16'(3 - i), rd('h20));
      check("front pwr", {15'h0, i == 3}, {15'h0, power_out});
      if (i == 1) begin
        check("front up 1", 16'h2222, rd('h21));
        check("front up 2", 16'h3333, rd('h22));
      end
    end
  endtask

  task automatic t_sort;
    logic [15:0] a_in [5] = '{16'h0882, 16'h7B9A, 16'hA009, 16'h49E9,
                              16'h5E45};
    logic [15:0] a_ex [5] = '{16'hA009, 16'h0882, 16'h49E9, 16'h5E45,
                              16'h7B9A};
    logic [15:0] b_ex [5] = '{16'h3, 16'h1, 16'h4, 16'h5, 16'h2};
    logic [15:0] d_in [4] = '{16'h0005, 16'hFFFF, 16'h0005, 16'h0000};
    logic [15:0] d_ex [4] = '{16'hFFFF, 16'h0000, 16'h0005, 16'h0005};
    logic [15:0] p_ex [4] = '{16'h2, 16'h4, 16'h1, 16'h3};
    for (int i = 0; i < 5; i++) begin
      poke('h100 + i, a_in[i]);
    end
    for (int i = 0; i < 4; i++) begin
      poke('h180 + i, d_in[i]);
    end
    run(SORT_OP, 1'b1, 16'h0000, 16'h0100, 16'h0140, 8'h05);
    check("sort pwr", 16'h0001, {15'h0, power_out});
    for (int i = 0; i < 5; i++) begin
      check("sort value", a_ex[i], rd('h100 + i));
      check("sort pos", b_ex[i], rd('h140 + i));
    end
    check("sort no ptr", 16'h0000, rd('h0FF));
    run(SORT_OP, 1'b1, 16'h0000, 16'h0180, 16'h01C0, 8'h04);
    for (int i = 0; i < 4; i++) begin
      check("stable value", d_ex[i], rd('h180 + i));
      check("stable pos", p_ex[i], rd('h1C0 + i));
    end
  endtask

  // Two unpowered commands back to back give two done pulses in a row
  task automatic t_power_off;
    int t;
    t = done_cnt + 2;
    poke('h180, 16'h0007);
    send(PUSH_FRONT_OP, 1'b0, 16'h0200, 16'h0010, 16'h0000, 8'h02);
    send(SORT_OP, 1'b0, 16'h0000, 16'h0180, 16'h01C0, 8'h04);
    wait_done(t);
    check("off ptr", 16'h0000, rd('h10));
    check("off first", 16'h5555, rd('h11));
    check("off sort", 16'h0007, rd('h180));
    check("off pwr", 16'h0000, {15'h0, power_out});
  endtask

  // Queue runs full while pushes are slow, then drains in order
  task automatic t_fill;
    int t;
    t = done_cnt + 6;
    poke('h40, 16'h0000);
    saw_full = 1'b0;
    for (int i = 0; i < 6; i++) begin
      poke('h210 + i, 16'h0100 + i);
      send(PUSH_FRONT_OP, 1'b1, 16'h0210 + i, 16'h0040, 16'h0000, 8'h08);
    end
    wait_done(t);
    check("queue refused", 16'h0001, {15'h0, saw_full});
    check("fill ptr", 16'h0006, rd('h40));
    check("fill pwr", 16'h0000, {15'h0, power_out});
    for (int j = 1; j <= 6; j++) begin
      check("fill order", 16'h0100 + 16'(6 - j), rd('h40 + j));
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; the 40000-cycle limit allows ample margin
  initial begin
    #(8 * 40000);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    t_push();
    t_reset();
    t_pop_back();
    t_pop_front();
    t_sort();
    t_power_off();
    t_fill();
    final_report();
  end
endmodule
`default_nettype wire
